// >>> rtl/ucc_pkg.sv
// Constants, field layouts and carrier types of the serial control block.
// Assumes one 20 MHz ref_clk domain and word-aligned AHB-Lite register access.
package ucc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS    = 8'h04;
	localparam logic [7:0] IDX_IRQ_EN    = 8'h05;
	localparam logic [7:0] IDX_RXTX_EN   = 8'h06;
	localparam logic [7:0] IDX_FRAME_FMT = 8'h07;

	// Values after reset
	localparam logic [7:0] RST_IRQ_EN    = 8'h00;
	localparam logic [7:0] RST_RXTX_EN   = 8'h00;
	localparam logic [7:0] RST_FRAME_FMT = 8'h03;
	localparam logic [4:0] RST_FLAGS     = 5'h04;

	// Writable bits; reserved bits read as zero
	localparam logic [7:0] WMASK_IRQ_EN    = 8'hFD;
	localparam logic [7:0] WMASK_RXTX_EN   = 8'hDF;
	localparam logic [7:0] WMASK_FRAME_FMT = 8'hFF;

	// Interrupt enable control fields
	localparam int unsigned POS_RX_DONE_IRQ_EN   = 7;
	localparam int unsigned POS_TX_DONE_IRQ_EN   = 6;
	localparam int unsigned POS_TX_EMPTY_IRQ_EN  = 5;
	localparam int unsigned POS_RX_START_IRQ_EN  = 4;
	localparam int unsigned POS_LOOPBACK_EN      = 3;
	localparam int unsigned POS_AUTOBAUD_ERR_EN  = 2;
	localparam int unsigned POS_RS485_EN         = 0;

	// Receive and transmit enables fields
	localparam int unsigned POS_RECEIVER_ON      = 7;
	localparam int unsigned POS_TRANSMITTER_ON   = 6;
	localparam int unsigned POS_FRAME_START_DET  = 4;
	localparam int unsigned POS_OPEN_DRAIN_EN    = 3;
	localparam int unsigned POS_RX_MODE_LSB      = 1;
	localparam int unsigned POS_MULTIPROC        = 0;

	// Frame format control fields
	localparam int unsigned POS_COMM_MODE_LSB    = 6;
	localparam int unsigned POS_PARITY_LSB       = 4;
	localparam int unsigned POS_STOP_BITS        = 3;
	localparam int unsigned POS_CHAR_SIZE_LSB    = 0;

	// Status flags sit in bits 7:3 of the status word
	localparam int unsigned POS_FLAGS_LSB        = 3;

	// Character size codes
	localparam logic [2:0] CHSZ_NINE_LOW  = 3'h6;
	localparam logic [2:0] CHSZ_NINE_HIGH = 3'h7;
	localparam logic [3:0] CHAR_BITS_MIN  = 4'h5;
	localparam logic [3:0] CHAR_BITS_8    = 4'h8;
	localparam logic [3:0] CHAR_BITS_9    = 4'h9;

	typedef enum logic [1:0] {
		RXM_NORMAL  = 2'h0,
		RXM_DOUBLE  = 2'h1,
		RXM_GENERIC = 2'h2,
		RXM_LIN     = 2'h3
	} ucc_rx_mode_t;

	typedef enum logic [1:0] {
		COMM_ASYNC    = 2'h0,
		COMM_SYNC     = 2'h1,
		COMM_INFRARED = 2'h2,
		COMM_HOST_SPI = 2'h3
	} ucc_comm_mode_t;

	typedef enum logic [1:0] {
		PAR_NONE     = 2'h0,
		PAR_RESERVED = 2'h1,
		PAR_EVEN     = 2'h2,
		PAR_ODD      = 2'h3
	} ucc_parity_t;

	// Events from the transceiver core, one-cycle pulses
	typedef struct packed {
		logic rxDone;
		logic txDone;
		logic txEmpty;
		logic rxStart;
		logic syncFieldErr;
	} ucc_evt_t;

	// Per-source interrupt requests, same order as the events
	typedef struct packed {
		logic rxDone;
		logic txDone;
		logic txEmpty;
		logic rxStart;
		logic autobaudErr;
	} ucc_irq_t;

	typedef struct packed {
		logic           receiverOn;
		logic           transmitterOn;
		logic           frameStartDetectEn;
		logic           openDrainEn;
		ucc_rx_mode_t   receiverModeSel;
		logic           doubleSpeed;
		logic           genericAutobaud;
		logic           linConstrainedAutobaud;
		logic           multiprocessorMode;
		logic           rs485En;
		logic           loopbackEn;
		ucc_comm_mode_t commModeSel;
		logic           syncMode;
		logic           infraredMode;
		logic           hostSpiMode;
		logic           frameLayoutValid;
		ucc_parity_t    paritySel;
		logic           parityEn;
		logic           parityOdd;
		logic           parityReserved;
		logic           stopBitsSel;
		logic [3:0]     charBits;
		logic           nineBitLowFirst;
		logic           charSizeReserved;
	} ucc_cfg_t;

endpackage : ucc_pkg

// >>> rtl/ucc_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the level is slow compared with the clock.
`timescale 1ns/1ps
`default_nettype none
module ucc_sync2 (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic async,
	output logic      synced
);
	logic stage1;
	logic next_stage1;
	logic next_synced;

	// Stage one is read only by stage two
	always_comb begin
		next_stage1 = async;
		next_synced = stage1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stage1 <= 1'b1;
			synced <= 1'b1;
		end else begin
			stage1 <= next_stage1;
			synced <= next_synced;
		end
	end
endmodule : ucc_sync2
`default_nettype wire

// >>> rtl/ucc_sticky_flag.sv
// One sticky status flag: set by a pulse, cleared by writing a one.
// Assumes set and clear pulses come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ucc_sticky_flag #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic setPulse,
	input  wire logic clrPulse,
	output logic      nextFlag,
	output logic      flag
);
	// Set wins so an event in the clearing cycle survives
	always_comb begin
		if (setPulse) begin
			nextFlag = 1'b1;
		end else if (clrPulse) begin
			nextFlag = 1'b0;
		end else begin
			nextFlag = flag;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= RESET_VAL;
		end else begin
			flag <= nextFlag;
		end
	end
endmodule : ucc_sticky_flag
`default_nettype wire

// >>> rtl/ucc_usart_control_config.sv
// Control and configuration registers of a serial transceiver, AHB-Lite slave.
// Assumes a transceiver core on ref_clk supplies event pulses and the transmit bit.
// How it works
// - Receive-complete request is enable bit 7 and its flag both set.
// - Transmit-complete request is enable bit 6 and its flag both set.
// - Data-empty request is enable bit 5 and its flag both set.
// - Receive-start request is enable bit 4 and its flag both set.
// - Loop-back bit 3 feeds receiver from own transmit line, ignores receive pin.
// - Auto-baud error request is enable bit 2 and sync error flag set.
// - Bit 0 of the first control register turns RS-485 operation on.
// - Receiver runs only while second control bit 7 is one.
// - Transmitter runs only while second control bit 6 is one.
// - Second control bit 4 turns start-of-frame detection on.
// - Second control bit 3 selects open-drain drive, else push-pull.
// - Receiver mode bits 2:1: normal, double speed, generic or LIN auto-baud.
// - Second control bit 0 turns multiprocessor mode on.
// - Third control bits 7:6: asynchronous, synchronous, infrared, host SPI.
// - Parity, stop and size layout holds in every mode but host SPI.
// - Parity bits 5:4: none, reserved, even, odd.
// - Bit 3 gives one or two transmitted stop bits; receiver ignores it.
// - Size bits 2:0: five to eight bits, or nine low or high first.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ucc_usart_control_config (
	input  wire logic            ref_clk,
	input  wire logic            srst,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire ucc_pkg::ucc_evt_t events,
	input  wire logic            txBit,
	input  wire logic            rxPin,
	output logic                 txPin,
	output logic                 txPinOeN,
	output logic                 rxToReceiver,
	output var ucc_pkg::ucc_cfg_t cfg,
	output var ucc_pkg::ucc_irq_t irqReq,
	output logic                 irq
);
	import ucc_pkg::*;

	logic [7:0]     interrupt_enable_control;
	logic [7:0]     receive_transmit_enables;
	logic [7:0]     frame_format_control;
	logic [7:0]     next_interrupt_enable_control;
	logic [7:0]     next_receive_transmit_enables;
	logic [7:0]     next_frame_format_control;
	logic           wrPend;
	logic           next_wrPend;
	logic [7:0]     wrIdx;
	logic [7:0]     next_wrIdx;
	logic [31:0]    next_hrdata;
	logic           next_hreadyout;
	logic           next_hresp;
	logic [4:0]     flagSet;
	logic [4:0]     flagClr;
	logic [4:0]     flags;
	logic [4:0]     nextFlags;
	logic [4:0]     nextEnables;
	ucc_irq_t       next_irqReq;
	logic           next_irq;
	ucc_cfg_t       next_cfg;
	logic           rxPinSync;
	logic           txLevel;
	logic           next_txPin;
	logic           next_txPinOeN;
	logic           next_rxToReceiver;
	logic           addrOk;
	logic           addrPhase;
	// Write strobes and event qualifiers
	logic           wordAccess;
	logic           wrStatus;
	logic           wrIrqEn;
	logic           wrRxTxEn;
	logic           wrFrameFmt;
	logic [7:0]     wrByte;
	logic           rxAllowed;
	logic           txAllowed;
	logic           startAllowed;
	logic           syncErrAllowed;

	// Register image for reads, zeros outside the map
	function automatic logic [7:0] readMux(
		input logic [7:0] idx,
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c,
		input logic [4:0] f
	);
		logic [7:0] val;
		val = 8'h00;
		case (idx)
			IDX_STATUS: val = {f, 3'h0};
			IDX_IRQ_EN:    val = a;
			IDX_RXTX_EN:   val = b;
			IDX_FRAME_FMT: val = c;
			default:    val = 8'h00;
		endcase
		return val;
	endfunction : readMux

	// Decode the three control registers into named configuration
	function automatic ucc_cfg_t decodeCfg(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c
	);
		ucc_cfg_t   d;
		logic [2:0] size;
		d = '0;
		size = c[POS_CHAR_SIZE_LSB +: 3];
		d.rs485En            = a[POS_RS485_EN];
		d.loopbackEn         = a[POS_LOOPBACK_EN];
		d.receiverOn         = b[POS_RECEIVER_ON];
		d.transmitterOn      = b[POS_TRANSMITTER_ON];
		d.frameStartDetectEn = b[POS_FRAME_START_DET];
		d.openDrainEn        = b[POS_OPEN_DRAIN_EN];
		d.multiprocessorMode = b[POS_MULTIPROC];
		d.receiverModeSel    = ucc_rx_mode_t'(b[POS_RX_MODE_LSB +: 2]);
		d.doubleSpeed            = d.receiverModeSel == RXM_DOUBLE;
		d.genericAutobaud        = d.receiverModeSel == RXM_GENERIC;
		d.linConstrainedAutobaud = d.receiverModeSel == RXM_LIN;
		d.commModeSel   = ucc_comm_mode_t'(c[POS_COMM_MODE_LSB +: 2]);
		d.syncMode      = d.commModeSel == COMM_SYNC;
		d.infraredMode  = d.commModeSel == COMM_INFRARED;
		d.hostSpiMode   = d.commModeSel == COMM_HOST_SPI;
		// Host SPI reuses these bits for other fields, so frame outputs stay zero
		d.frameLayoutValid = !d.hostSpiMode;
		if (d.frameLayoutValid) begin
			d.paritySel      = ucc_parity_t'(c[POS_PARITY_LSB +: 2]);
			d.parityEn       = d.paritySel == PAR_EVEN || d.paritySel == PAR_ODD;
			d.parityOdd      = d.paritySel == PAR_ODD;
			d.parityReserved = d.paritySel == PAR_RESERVED;
			// Only the transmitter looks at the stop bit count
			d.stopBitsSel    = c[POS_STOP_BITS];
			case (size)
				CHSZ_NINE_LOW: begin
					d.charBits        = CHAR_BITS_9;
					d.nineBitLowFirst = 1'b1;
				end
				CHSZ_NINE_HIGH: begin
					d.charBits        = CHAR_BITS_9;
				end
				default: begin
					if (size[2]) begin
						// Reserved sizes fall back to eight bits
						d.charBits         = CHAR_BITS_8;
						d.charSizeReserved = 1'b1;
					end else begin
						d.charBits = CHAR_BITS_MIN + {2'h0, size[1:0]};
					end
				end
			endcase
		end
		return d;
	endfunction : decodeCfg

	// Bus slave and control registers
	always_comb begin
		addrOk      = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
		addrPhase   = hsel && hready && htrans[1];
		// Only whole-word stores land; a narrow one would leave a byte half written
		wordAccess  = hsize == 3'h2;
		wrByte      = hwdata[7:0];
		wrStatus    = wrPend && wrIdx == IDX_STATUS;
		wrIrqEn     = wrPend && wrIdx == IDX_IRQ_EN;
		wrRxTxEn    = wrPend && wrIdx == IDX_RXTX_EN;
		wrFrameFmt  = wrPend && wrIdx == IDX_FRAME_FMT;
		next_interrupt_enable_control  = interrupt_enable_control;
		next_receive_transmit_enables  = receive_transmit_enables;
		next_frame_format_control  = frame_format_control;
		next_wrPend = 1'b0;
		next_wrIdx  = wrIdx;
		next_hrdata = hrdata;
		flagClr     = 5'h00;
		// Zero wait states and an OKAY response on every transfer
		next_hreadyout = 1'b1;
		next_hresp     = 1'b0;
		// Status is write-one-to-clear; zeros leave the flags alone
		if (wrStatus) begin
			flagClr = wrByte[POS_FLAGS_LSB +: 5];
		end
		if (wrIrqEn) begin
			next_interrupt_enable_control = wrByte & WMASK_IRQ_EN;
		end
		if (wrRxTxEn) begin
			next_receive_transmit_enables = wrByte & WMASK_RXTX_EN;
		end
		if (wrFrameFmt) begin
			next_frame_format_control = wrByte & WMASK_FRAME_FMT;
		end
		if (addrPhase) begin
			next_wrPend = hwrite && addrOk && wordAccess;
			next_wrIdx  = haddr[9:2];
			if (!hwrite) begin
				// Next control values forward a control-register write landing in this same cycle
				next_hrdata = 32'h0;
				if (addrOk) begin
					next_hrdata[7:0] = readMux(haddr[9:2], next_interrupt_enable_control, next_receive_transmit_enables,
						next_frame_format_control, flags);
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			interrupt_enable_control     <= RST_IRQ_EN;
			receive_transmit_enables     <= RST_RXTX_EN;
			frame_format_control     <= RST_FRAME_FMT;
			wrPend    <= 1'b0;
			wrIdx     <= 8'h00;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			interrupt_enable_control     <= next_interrupt_enable_control;
			receive_transmit_enables     <= next_receive_transmit_enables;
			frame_format_control     <= next_frame_format_control;
			wrPend    <= next_wrPend;
			wrIdx     <= next_wrIdx;
			hrdata    <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp     <= next_hresp;
		end
	end

	// Event qualification; a disabled direction raises no done or start flag, but data-empty and sync error ignore the enables
	always_comb begin
		rxAllowed      = receive_transmit_enables[POS_RECEIVER_ON];
		txAllowed      = receive_transmit_enables[POS_TRANSMITTER_ON];
		startAllowed   = rxAllowed && receive_transmit_enables[POS_FRAME_START_DET]
			&& !cfg.hostSpiMode;
		// Only the two auto-baud modes measure a sync field
		syncErrAllowed = receive_transmit_enables[POS_RX_MODE_LSB + 1];
		flagSet[4] = events.rxDone && rxAllowed;
		flagSet[3] = events.txDone && txAllowed;
		flagSet[2] = events.txEmpty;
		flagSet[1] = events.rxStart && startAllowed;
		flagSet[0] = events.syncFieldErr && syncErrAllowed;
	end

	generate
		for (genvar i = 0; i < 5; i++) begin : g_flag
			ucc_sticky_flag #(
				.RESET_VAL (RST_FLAGS[i])
			) u_flag (
				.clk      (ref_clk),
				.srst     (srst),
				.setPulse (flagSet[i]),
				.clrPulse (flagClr[i]),
				.nextFlag (nextFlags[i]),
				.flag     (flags[i])
			);
		end
	endgenerate

	// Requests follow the next state so they coincide with flag and enable
	always_comb begin
		nextEnables = {next_interrupt_enable_control[POS_RX_DONE_IRQ_EN], next_interrupt_enable_control[POS_TX_DONE_IRQ_EN],
			next_interrupt_enable_control[POS_TX_EMPTY_IRQ_EN], next_interrupt_enable_control[POS_RX_START_IRQ_EN],
			next_interrupt_enable_control[POS_AUTOBAUD_ERR_EN]};
		next_irqReq.rxDone      = nextFlags[4] && nextEnables[4];
		next_irqReq.txDone      = nextFlags[3] && nextEnables[3];
		next_irqReq.txEmpty     = nextFlags[2] && nextEnables[2];
		next_irqReq.rxStart     = nextFlags[1] && nextEnables[1];
		next_irqReq.autobaudErr = nextFlags[0] && nextEnables[0];
		// One level output, high while any unmasked flag is set
		next_irq = |next_irqReq;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irqReq <= '0;
			irq    <= 1'b0;
		end else begin
			irqReq <= next_irqReq;
			irq    <= next_irq;
		end
	end

	// Decoded from next values so a field changes at the edge its register does
	always_comb begin
		next_cfg = decodeCfg(next_interrupt_enable_control, next_receive_transmit_enables, next_frame_format_control);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg <= '0;
		end else begin
			cfg <= next_cfg;
		end
	end

	// Receive pin is asynchronous to ref_clk
	ucc_sync2 u_rx_sync (
		.clk    (ref_clk),
		.srst   (srst),
		.async  (rxPin),
		.synced (rxPinSync)
	);

	// Line drive and receiver input
	always_comb begin
		// An idle transmitter holds the line at mark
		txLevel = cfg.transmitterOn ? txBit : 1'b1;
		if (cfg.openDrainEn) begin
			// Open drain only pulls low; a one releases the line
			next_txPin    = !cfg.transmitterOn;
			next_txPinOeN = !cfg.transmitterOn || txLevel;
		end else begin
			next_txPin    = txLevel;
			next_txPinOeN = !cfg.transmitterOn;
		end
		if (!cfg.receiverOn) begin
			next_rxToReceiver = 1'b1;
		end else if (cfg.loopbackEn) begin
			next_rxToReceiver = txLevel;
		end else begin
			next_rxToReceiver = rxPinSync;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			txPin        <= 1'b1;
			txPinOeN     <= 1'b1;
			rxToReceiver <= 1'b1;
		end else begin
			txPin        <= next_txPin;
			txPinOeN     <= next_txPinOeN;
			rxToReceiver <= next_rxToReceiver;
		end
	end

endmodule : ucc_usart_control_config
`default_nettype wire

// >>> tb/ucc_checker.sv
// Assertions on pin paths, decode and interrupt outputs of the control block.
// Assumes binding to ucc_usart_control_config on the one ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module ucc_checker (
	input wire logic              ref_clk,
	input wire logic              srst,
	input wire logic              txBit,
	input wire logic              rxPin,
	input wire logic              txPin,
	input wire logic              txPinOeN,
	input wire logic              rxToReceiver,
	input wire ucc_pkg::ucc_cfg_t cfg,
	input wire ucc_pkg::ucc_irq_t irqReq,
	input wire logic              irq
);
	import ucc_pkg::*;
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// Four samples cover the sync chain and the output flop
	sequence rxSteady;
		(cfg.receiverOn && !cfg.loopbackEn && $stable(rxPin))[*4];
	endsequence
	sequence txSteady;
		(cfg.transmitterOn && !cfg.openDrainEn && $stable(txBit))[*4];
	endsequence
	a_irq_any: assert property (irq == |irqReq)
		else $error("irq is not the OR of the requests");
	a_rx_follow: assert property (rxSteady |-> rxToReceiver == rxPin)
		else $error("receiver input does not follow the pin");
	a_loop_path: assert property (txSteady and (cfg.loopbackEn && cfg.receiverOn)[*4] |->
		rxToReceiver == txBit)
		else $error("loop-back does not feed the transmit level");
	a_tx_follow: assert property (txSteady |-> txPin == txBit)
		else $error("push-pull pin does not follow the transmit bit");
	a_rx_off: assert property ((!cfg.receiverOn)[*2] |-> rxToReceiver)
		else $error("idle receiver input is not high");
	a_tx_off: assert property ((!cfg.transmitterOn)[*2] |-> txPin && txPinOeN)
		else $error("stopped transmitter still drives");
	a_push_pull: assert property ((cfg.transmitterOn && !cfg.openDrainEn)[*2] |-> !txPinOeN)
		else $error("push-pull pin not driven");
	a_open_drain: assert property ((cfg.transmitterOn && cfg.openDrainEn)[*2] |-> !txPin)
		else $error("open-drain pin drives high");
	a_layout_mode: assert property (!$past(srst) |->
		cfg.frameLayoutValid == (cfg.commModeSel != COMM_HOST_SPI))
		else $error("frame layout validity wrong");
	a_parity_dec: assert property (!$past(srst) && cfg.frameLayoutValid |->
		cfg.parityEn == cfg.paritySel[1] && cfg.parityOdd == (cfg.paritySel == PAR_ODD))
		else $error("parity decode wrong");
	a_receiver_mode_sel_dec: assert property (cfg.doubleSpeed == (cfg.receiverModeSel == RXM_DOUBLE) &&
		cfg.linConstrainedAutobaud == (cfg.receiverModeSel == RXM_LIN))
		else $error("receiver mode decode wrong");
endmodule : ucc_checker
bind ucc_usart_control_config ucc_checker chk (.ref_clk, .srst, .txBit, .rxPin, .txPin,
	.txPinOeN, .rxToReceiver, .cfg, .irqReq, .irq);
`default_nettype wire

// >>> tb/ucc_station.sv
// Remote serial station: sends one character on the receive pin, LSB first.
// Assumes bit time in ref_clk cycles; line idles at its pull-up level.
`timescale 1ns/1ps
`default_nettype none
module ucc_station #(
	parameter int BIT = 16
) (
	input  wire logic       ref_clk,
	input  wire logic       send,
	input  wire logic [7:0] data,
	output logic            rxPin,
	output logic            busy
);
	logic [9:0] frame;
	int         cnt;
	initial begin
		rxPin = 1'h1;
		busy  = 1'h0;
		cnt   = 0;
	end
	always @(posedge ref_clk) begin
		if (send && !busy) begin
			frame <= {1'h1, data, 1'h0};
			cnt   <= 10 * BIT;
			busy  <= 1'h1;
		end else if (cnt > 0) begin
			rxPin <= frame[9 - (cnt - 1) / BIT];
			cnt   <= cnt - 1;
		end else begin
			rxPin <= 1'h1;
			busy  <= 1'h0;
		end
	end
endmodule : ucc_station
`default_nettype wire

// >>> tb/test_usart_control_config.sv
// Self-checking bench: AHB-Lite register calls, event pulses and a remote station.
// Assumes hready is looped from hreadyout, the single slave on the bus.
`timescale 1ns/1ps
`default_nettype none
module test_usart_control_config;
	import ucc_pkg::*;
	localparam int BIT = 16;
	logic        ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
	logic        txBit, txPin, txPinOeN, rxPin, rxToReceiver, irq, send, busy;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  sdata, got;
	ucc_evt_t    events;
	ucc_cfg_t    cfg;
	ucc_irq_t    irqReq;
	int          numErrors, comparisons, cycles;
	assign hready = hreadyout;
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	ucc_usart_control_config DUT (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .events, .txBit, .rxPin, .txPin,
		.txPinOeN, .rxToReceiver, .cfg, .irqReq, .irq);
	ucc_station #(.BIT(BIT)) station (.ref_clk, .send, .data(sdata), .rxPin, .busy);
	task automatic giveVerdict();
		$display("Counts: %0d mismatches, %0d comparisons", numErrors, comparisons);
		if (numErrors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : giveVerdict
	// A stuck handshake ends here rather than hanging the run
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			numErrors = numErrors + 1;
			giveVerdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			numErrors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel   <= 1'h1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge ref_clk);
		while (hready !== 1'h1) @(posedge ref_clk);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hready !== 1'h1) @(posedge ref_clk);
		rd = hrdata;
	endtask : xfer
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		xfer(a, 1'h0, 32'h0);
		check(rd, e);
		check(hresp, 1'h0);
	endtask : rdchk
	task automatic sendChar(input logic [7:0] d);
		while (busy !== 1'h0) tick(1);
		sdata <= d;
		send  <= 1'h1;
		tick(1);
		send  <= 1'h0;
	endtask : sendChar
	initial begin
		{srst, hsel, hwrite, txBit, send} = 5'h12;
		{haddr, hwdata, htrans, hsize, sdata} = {64'h0, 2'h0, 3'h2, 8'h0};
		events = '0;
		{numErrors, comparisons, cycles} = '0;
		tick(2);
		srst <= 1'h0;
		tick(1);
		xfer(32'h40, 1'h1, 32'hFF);
		rdchk(32'h40, 32'h0);
		rdchk(32'h18, 32'h0);
		rdchk(32'h1C, 32'h3);
		rdchk(32'h14, 32'h0);
		rdchk(32'h10, 32'h20);
		xfer(32'h14, 1'h1, 32'hFF);
		rdchk(32'h14, 32'hFD);
		xfer(32'h18, 1'h1, 32'hF9);
		rdchk(32'h18, 32'hD9);
		$display("Test register access done");
		for (int c = 0; c < 4; c++) begin
			xfer(32'h1C, 1'h1, {24'h0, c[1:0], 6'h3});
			tick(1);
			check({cfg.commModeSel, cfg.frameLayoutValid, cfg.syncMode, cfg.infraredMode,
				cfg.hostSpiMode}, {c[1:0], c != 3, c == 1, c == 2, c == 3});
		end
		for (int i = 0; i < 8; i++) begin
			xfer(32'h1C, 1'h1, {24'h0, 2'h1, i[1:0], i[0], i[2:0]});
			tick(1);
			check({cfg.paritySel, cfg.parityEn, cfg.parityOdd, cfg.parityReserved},
				{i[1:0], i[1], i[1:0] == 2'h3, i[1:0] == 2'h1});
			check({cfg.stopBitsSel, cfg.charBits, cfg.nineBitLowFirst, cfg.charSizeReserved},
				{i[0], i < 4 ? 4'(i + 5) : (i > 5 ? 4'h9 : 4'h8), i == 6, i == 4 || i == 5});
		end
		for (int m = 0; m < 4; m++) begin
			xfer(32'h18, 1'h1, {27'h0, m[0], 1'h0, m[1:0], m[1]});
			xfer(32'h14, 1'h1, {31'h0, m[1]});
			tick(1);
			check(cfg.receiverModeSel, m);
			check({cfg.doubleSpeed, cfg.genericAutobaud, cfg.linConstrainedAutobaud},
				{m == 1, m == 2, m == 3});
			check({cfg.frameStartDetectEn, cfg.multiprocessorMode, cfg.rs485En},
				{m[0], m[1], m[1]});
		end
		$display("Test decode done");
		xfer(32'h18, 1'h1, 32'hD4);
		xfer(32'h14, 1'h1, 32'h0);
		xfer(32'h10, 1'h1, 32'hF8);
		for (int k = 0; k < 5; k++) begin
			events <= 5'h10 >> k;
			tick(1);
			events <= '0;
			tick(1);
			check(irq, 1'h0);
			rdchk(32'h10, 8'h80 >> k);
			xfer(32'h14, 1'h1, 8'h80 >> (k + (k == 4)));
			tick(1);
			check(irqReq, 5'h10 >> k);
			check(irq, 1'h1);
			xfer(32'h10, 1'h1, 8'h80 >> k);
			tick(1);
			check(irq, 1'h0);
			xfer(32'h14, 1'h1, 32'h0);
		end
		$display("Test interrupts done");
		xfer(32'h18, 1'h1, 32'hC0);
		sendChar(8'hA5);
		while (rxToReceiver !== 1'h0) tick(1);
		tick(BIT / 2);
		for (int b = 0; b < 8; b++) begin
			tick(BIT);
			got[b] = rxToReceiver;
		end
		check(got, 8'hA5);
		xfer(32'h14, 1'h1, 32'h8);
		sendChar(8'h0);
		tick(BIT * 4);
		check(rxToReceiver, 1'h1);
		txBit <= 1'h0;
		tick(6);
		check({rxToReceiver, txPin, txPinOeN}, 3'h0);
		xfer(32'h18, 1'h1, 32'hC8);
		tick(3);
		check({txPin, txPinOeN}, 2'h0);
		txBit <= 1'h1;
		tick(4);
		check({txPin, txPinOeN}, 2'h1);
		xfer(32'h18, 1'h1, 32'h80);
		tick(3);
		check({txPin, txPinOeN}, 2'h3);
		xfer(32'h14, 1'h1, 32'h0);
		xfer(32'h18, 1'h1, 32'h0);
		sendChar(8'h0);
		tick(BIT * 3);
		check(rxToReceiver, 1'h1);
		$display("Test pin paths done");
		giveVerdict();
	end
endmodule : test_usart_control_config
`default_nettype wire
